// file: verilog/alpha_refresh_pkg.sv
// shared constants and types for the alpha refresh block
package alpha_refresh_pkg;
	localparam int FS_WORDS = 2480;
	localparam int WORD_W = 16;
	localparam int DISP_W = 15;
	localparam int ROWS = 31;
	localparam int COLS = 80;
	localparam int ADDR_W = 12;
	localparam int BYTE_W = 8;
	localparam int GFX_W = 16;
	localparam int GFX_CTRL_W = 4;
	// apb byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	// control register fields
	localparam int CTRL_SELF_CHECK = 0;
	localparam int CTRL_DMA_MODE = 1;
	localparam int CTRL_FLAG_GATE = 2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// status register fields
	localparam int ST_DISPLAY_MODE = 0;
	localparam int ST_FAULT = 1;
	localparam int ST_SELF_CHECK = 2;
	localparam int ST_ROW_LSB = 8;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	typedef enum logic [0:0] {
		LOAD_IDLE = 1'b0,
		LOAD_RUN = 1'b1
	} load_state_e;
	typedef struct packed {
		logic write_sel;
		logic out_ctrl;
		logic dir_sel;
		logic isolate;
	} fs_ctrl_s;
endpackage : alpha_refresh_pkg

// file: verilog/alpha_refresh_module.sv
// frame store, ping-pong line buffer and controller for the alpha display
`timescale 1ns/1ns
module alpha_refresh_module (
	input wire logic clock, // 10 MHz
	input wire logic rst_n, // synchronous reset
	input wire logic ce, // freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic dma_valid, // dma word offered
	input wire logic [alpha_refresh_pkg::WORD_W-1:0] dma_data, // dma word
	output logic dma_ready, // dma word accepted
	input wire logic manual_self_check, // pushbutton level
	input wire logic next_char_strobe, // display wants next character
	input wire logic next_row_strobe, // display starts next row
	input wire logic next_frame_strobe, // display starts next frame
	output logic [alpha_refresh_pkg::DISP_W-1:0] disp_data, // character out
	output logic row_load_clock, // load pulse into fill register
	output logic self_check_request, // line buffer in self check
	output logic pattern_fault, // line buffer error seen
	output logic [alpha_refresh_pkg::ADDR_W-1:0] fs_addr, // store address
	output alpha_refresh_pkg::fs_ctrl_s fs_ctrl, // store and buffer controls
	output logic output_status_flag_gate, // status/flag drive enable
	output logic host_status, // status line to host bus
	output logic host_flag, // flag line to host bus
	input wire logic [alpha_refresh_pkg::GFX_W-1:0] gfx_in, // graphics data
	input wire logic [alpha_refresh_pkg::GFX_CTRL_W-1:0] gfx_ctrl_in, // ctrl
	output logic [alpha_refresh_pkg::GFX_W-1:0] gfx_out, // to display
	output logic [alpha_refresh_pkg::GFX_CTRL_W-1:0] gfx_ctrl_out // to display
);
	import alpha_refresh_pkg::*;

	logic [WORD_W-1:0] frame_store [0:FS_WORDS-1];
	logic [WORD_W-1:0] line_a [0:COLS-1];
	logic [WORD_W-1:0] line_b [0:COLS-1];

	logic [7:0] ctrl_ff;
	logic [ADDR_W-1:0] host_addr_ff;
	logic [ADDR_W-1:0] rd_addr_ff;
	load_state_e load_state_ff;
	load_state_e nxt_load_state;
	logic [6:0] load_idx_ff;
	logic [4:0] load_row_ff;
	logic [6:0] shift_idx_ff;
	logic shift_sel_ff; // 0: line_a shifts, line_b fills
	logic [WORD_W-1:0] pat_ff;
	logic [WORD_W-1:0] expect_ff;
	logic fault_ff;
	logic [DISP_W-1:0] disp_ff;
	logic [GFX_W-1:0] gfx_ff;
	logic [GFX_CTRL_W-1:0] gfx_ctrl_ff;

	logic loading;
	logic apb_acc;
	logic is_ctrl;
	logic is_addr;
	logic is_data;
	logic is_status;
	logic mapped;
	logic apb_done;
	logic host_wr;
	logic host_rd;
	logic dma_wr;
	logic store_wr;
	logic [WORD_W-1:0] store_wdata;
	logic load_step;
	logic start_load;
	logic [WORD_W-1:0] load_word;
	logic [WORD_W-1:0] shift_word;
	logic fault_set;
	logic fault_clr;

	// wrap the store address at the end of the frame
	function automatic logic [ADDR_W-1:0] step_addr(
		input logic [ADDR_W-1:0] a
	);
		if (a == ADDR_W'(FS_WORDS - 1)) begin
			step_addr = '0;
		end else begin
			step_addr = a + 1'b1;
		end
	endfunction : step_addr

	assign loading = (load_state_ff == LOAD_RUN);
	assign apb_acc = psel & penable;
	assign is_ctrl = (paddr == OFS_CTRL);
	assign is_addr = (paddr == OFS_ADDR);
	assign is_data = (paddr == OFS_DATA);
	assign is_status = (paddr == OFS_STATUS);
	assign mapped = is_ctrl | is_addr | is_data | is_status;

	// data access waits out a row load; the row load is short
	assign pready = ce & ~(is_data & loading);
	assign pslverr = apb_acc & ~mapped;
	assign apb_done = apb_acc & pready;

	assign host_wr = apb_done & pwrite & is_data;
	assign host_rd = apb_done & ~pwrite & is_data;
	// apb gets the store first; dma waits a cycle
	assign dma_ready = ce & ctrl_ff[CTRL_DMA_MODE] & ~loading &
		~(apb_acc & is_data);
	assign dma_wr = dma_valid & dma_ready;
	assign store_wr = host_wr | dma_wr;
	assign store_wdata = host_wr ? pwdata[WORD_W-1:0] : dma_data;

	assign self_check_request = manual_self_check |
		ctrl_ff[CTRL_SELF_CHECK];

	assign load_step = ce & loading;
	assign start_load = ce & (next_frame_strobe |
		(next_row_strobe & (load_row_ff < 5'(ROWS))));
	assign row_load_clock = load_step;

	// self check swaps the store word for the counter pattern
	assign load_word = self_check_request ? pat_ff :
		frame_store[rd_addr_ff];
	assign shift_word = shift_sel_ff ? line_b[shift_idx_ff] :
		line_a[shift_idx_ff];

	always_comb begin
		fs_ctrl.write_sel = store_wr;
		fs_ctrl.out_ctrl = store_wr | loading;
		fs_ctrl.dir_sel = host_rd;
		fs_ctrl.isolate = loading;
		fs_addr = loading ? rd_addr_ff : host_addr_ff;
	end

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel & ~pwrite) begin
			if (is_ctrl) begin
				prdata[BYTE_W-1:0] = ctrl_ff;
			end else if (is_addr) begin
				prdata[ADDR_W-1:0] = host_addr_ff;
			end else if (is_data) begin
				prdata[WORD_W-1:0] = frame_store[host_addr_ff];
			end else if (is_status) begin
				prdata[ST_DISPLAY_MODE] = loading;
				prdata[ST_FAULT] = fault_ff;
				prdata[ST_SELF_CHECK] = self_check_request;
				prdata[ST_ROW_LSB +: 5] = load_row_ff;
			end
		end
	end

	// control byte travels on the low data lines
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_ff <= CTRL_RESET;
		end else if (apb_done & pwrite & is_ctrl) begin
			ctrl_ff <= pwdata[BYTE_W-1:0];
		end
	end

	// host address counter steps on each store access
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			host_addr_ff <= ADDR_RESET;
		end else if (apb_done & pwrite & is_addr) begin
			host_addr_ff <= pwdata[ADDR_W-1:0];
		end else if (store_wr | host_rd) begin
			host_addr_ff <= step_addr(host_addr_ff);
		end
	end

	// storage arrays carry no reset
	always_ff @(posedge clock) begin
		if (ce & store_wr) begin
			frame_store[host_addr_ff] <= store_wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (load_step) begin
			if (shift_sel_ff) begin
				line_a[load_idx_ff] <= load_word;
			end else begin
				line_b[load_idx_ff] <= load_word;
			end
		end
	end

	// display mode lasts one row load, the rest is host mode
	always_comb begin
		nxt_load_state = load_state_ff;
		case (load_state_ff)
			LOAD_IDLE: begin
				if (start_load) begin
					nxt_load_state = LOAD_RUN;
				end
			end
			LOAD_RUN: begin
				if (load_idx_ff == 7'(COLS - 1)) begin
					nxt_load_state = LOAD_IDLE;
				end
			end
			default: begin
				nxt_load_state = LOAD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			load_state_ff <= LOAD_IDLE;
		end else if (ce) begin
			load_state_ff <= nxt_load_state;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			load_idx_ff <= 7'h00;
		end else if (ce) begin
			if (start_load & ~loading) begin
				load_idx_ff <= 7'h00;
			end else if (load_step) begin
				load_idx_ff <= load_idx_ff + 7'h01;
			end
		end
	end

	// read counters follow the frame strobe
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rd_addr_ff <= ADDR_RESET;
			load_row_ff <= 5'h00;
		end else if (ce) begin
			if (next_frame_strobe) begin
				rd_addr_ff <= ADDR_RESET;
				load_row_ff <= 5'h00;
			end else if (load_step) begin
				rd_addr_ff <= step_addr(rd_addr_ff);
				if (load_idx_ff == 7'(COLS - 1)) begin
					load_row_ff <= load_row_ff + 5'h01;
				end
			end
		end
	end

	// frame strobe acts as a row start too
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shift_sel_ff <= 1'b0;
			shift_idx_ff <= 7'h00;
		end else if (ce) begin
			if (next_frame_strobe | next_row_strobe) begin
				shift_sel_ff <= ~shift_sel_ff;
				shift_idx_ff <= 7'h00;
			end else if (next_char_strobe &
				(shift_idx_ff < 7'(COLS))) begin
				shift_idx_ff <= shift_idx_ff + 7'h01;
			end
		end
	end

	// top bit of the path is dropped at the display
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			disp_ff <= '0;
		end else if (ce & next_char_strobe & (shift_idx_ff < 7'(COLS))) begin
			disp_ff <= shift_word[DISP_W-1:0];
		end
	end
	assign disp_data = disp_ff;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pat_ff <= '0;
			expect_ff <= '0;
		end else if (ce) begin
			if (next_frame_strobe) begin
				pat_ff <= '0;
				expect_ff <= '0;
			end else begin
				if (load_step & self_check_request) begin
					pat_ff <= pat_ff + 1'b1;
				end
				if (next_char_strobe & self_check_request &
					(shift_idx_ff < 7'(COLS))) begin
					expect_ff <= expect_ff + 1'b1;
				end
			end
		end
	end

	// overrun past a row, or a wrong pattern word, is an error
	assign fault_set = ce & next_char_strobe &
		((shift_idx_ff == 7'(COLS)) |
		(self_check_request & (shift_word != expect_ff)));
	assign fault_clr = apb_done & pwrite & is_status & pwdata[ST_FAULT];

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fault_ff <= 1'b0;
		end else if (fault_set) begin
			fault_ff <= 1'b1;
		end else if (fault_clr) begin
			fault_ff <= 1'b0;
		end
	end
	assign pattern_fault = fault_ff;

	// host bus lines stay quiet unless the gate is open
	assign output_status_flag_gate = ctrl_ff[CTRL_FLAG_GATE];
	assign host_status = output_status_flag_gate & fault_ff;
	assign host_flag = output_status_flag_gate & ~loading;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gfx_ff <= '0;
			gfx_ctrl_ff <= '0;
		end else if (ce) begin
			gfx_ff <= gfx_in;
			gfx_ctrl_ff <= gfx_ctrl_in;
		end
	end
	assign gfx_out = gfx_ff;
	assign gfx_ctrl_out = gfx_ctrl_ff;
endmodule : alpha_refresh_module

// file: tb/alpha_refresh_checker.sv
// concurrent checks on the alpha refresh block ports
`timescale 1ns/1ns
module alpha_refresh_checker (
	input wire logic clock, // clock
	input wire logic rst_n, // sync reset
	input wire logic ce, // clock enable
	input wire logic psel, // apb select
	input wire logic penable, // apb access
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb address
	input wire logic pready, // apb ready
	input wire logic manual_self_check, // pushbutton
	input wire logic next_frame_strobe, // frame strobe
	input wire logic row_load_clock, // load pulse
	input wire logic self_check_request, // self check
	input wire logic [11:0] fs_addr, // store address
	input wire alpha_refresh_pkg::fs_ctrl_s fs_ctrl, // store controls
	input wire logic output_status_flag_gate, // gate
	input wire logic host_status, // status line
	input wire logic host_flag // flag line
);
	import alpha_refresh_pkg::*;
	logic [7:0] lcnt_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// consecutive load cycles, cleared between rows
	always_ff @(posedge clock) begin
		if (!rst_n || !fs_ctrl.isolate)
			lcnt_ff <= 8'h00;
		else
			lcnt_ff <= lcnt_ff + 8'h01;
	end
	sequence s_load_start;
		fs_ctrl.isolate && fs_addr == 12'h000;
	endsequence
	property out_ok;
		fs_ctrl.out_ctrl == (fs_ctrl.write_sel || fs_ctrl.isolate);
	endproperty
	a_frame_load: assert property (
		ce && next_frame_strobe |=> s_load_start)
		else $error("frame strobe did not start row load at zero");
	a_load_len: assert property (
		$fell(fs_ctrl.isolate) |-> lcnt_ff == 8'h50)
		else $error("row load length wrong");
	a_addr_step: assert property (fs_ctrl.isolate && $past(fs_ctrl.isolate)
		|-> fs_addr == $past(fs_addr) + 12'h001) else $error("load addr step");
	a_load_clk: assert property (fs_ctrl.isolate |-> row_load_clock)
		else $error("no load clock while loading");
	a_out_ctrl: assert property (out_ok)
		else $error("output control wrong");
	a_no_wr_load: assert property (fs_ctrl.isolate |-> !fs_ctrl.write_sel)
		else $error("store written during row load");
	a_data_stall: assert property (psel && penable && paddr == 8'h08
		&& fs_ctrl.isolate |-> !pready) else $error("data access during load");
	a_store_wr: assert property (psel && penable && pwrite && pready
		&& paddr == 8'h08 |-> fs_ctrl.write_sel) else $error("no store write");
	a_self_req: assert property (manual_self_check |-> self_check_request)
		else $error("pushbutton ignored");
	a_flag_gate: assert property (!output_status_flag_gate
		|-> !host_status && !host_flag) else $error("status without gate");
endmodule : alpha_refresh_checker
bind alpha_refresh_module alpha_refresh_checker chk (.clock(clock),
	.rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .manual_self_check(manual_self_check),
	.next_frame_strobe(next_frame_strobe), .row_load_clock(row_load_clock),
	.self_check_request(self_check_request), .fs_addr(fs_addr),
	.fs_ctrl(fs_ctrl), .output_status_flag_gate(output_status_flag_gate),
	.host_status(host_status), .host_flag(host_flag));

// file: tb/display_model.sv
// display side strobes that pace row loading and shifting
`timescale 1ns/1ns
module display_model (
	input wire logic clock, // shared clock
	output logic next_char_strobe, // next character
	output logic next_row_strobe, // next row
	output logic next_frame_strobe // next frame
);
	initial begin
		next_char_strobe = 1'b0;
		next_row_strobe = 1'b0;
		next_frame_strobe = 1'b0;
	end
	// one-cycle pulse; m is frame, row, char
	task strobe(input logic [2:0] m);
		@(posedge clock);
		{next_frame_strobe, next_row_strobe, next_char_strobe} <= m;
		@(posedge clock);
		{next_frame_strobe, next_row_strobe, next_char_strobe} <= 3'b000;
		// return mid-cycle: outputs launched at the strobe edge have settled
		@(negedge clock);
	endtask : strobe
endmodule : display_model

// file: tb/testbench.sv
// self-checking bench for the alpha refresh block
`timescale 1ns/1ns
module testbench;
	import alpha_refresh_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic dma_valid = 1'b0;
	logic [15:0] dma_data = 16'h0;
	logic manual_self_check = 1'b0;
	logic [15:0] gfx_in = 16'h0;
	logic [3:0] gfx_ctrl_in = 4'h0;
	logic [31:0] prdata, q;
	logic pready, pslverr, dma_ready, se;
	logic next_char_strobe, next_row_strobe, next_frame_strobe;
	logic [14:0] disp_data;
	logic row_load_clock, self_check_request, pattern_fault;
	logic [11:0] fs_addr;
	fs_ctrl_s fs_ctrl;
	logic output_status_flag_gate, host_status, host_flag;
	logic [15:0] gfx_out;
	logic [3:0] gfx_ctrl_out;
	int err_total = 0;
	int num_checks = 0;
	always #50 clock = ~clock;
	alpha_refresh_module uut (.clock(clock), .rst_n(rst_n), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
		.manual_self_check(manual_self_check),
		.next_char_strobe(next_char_strobe), .next_row_strobe(next_row_strobe),
		.next_frame_strobe(next_frame_strobe), .disp_data(disp_data),
		.row_load_clock(row_load_clock), .self_check_request(self_check_request),
		.pattern_fault(pattern_fault), .fs_addr(fs_addr), .fs_ctrl(fs_ctrl),
		.output_status_flag_gate(output_status_flag_gate),
		.host_status(host_status), .host_flag(host_flag), .gfx_in(gfx_in),
		.gfx_ctrl_in(gfx_ctrl_in), .gfx_out(gfx_out),
		.gfx_ctrl_out(gfx_ctrl_out));
	display_model disp (.clock(clock), .next_char_strobe(next_char_strobe),
		.next_row_strobe(next_row_strobe),
		.next_frame_strobe(next_frame_strobe));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task end_sim;
		$display("mismatches %0d checks %0d", err_total, num_checks);
		if (err_total == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	// apb transfer; read data and error taken at the ready edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task t_store;
		apb(1'b1, OFS_ADDR, 32'h0);
		for (int i = 0; i < 80; i++)
			apb(1'b1, OFS_DATA, 32'h9000 + i);
		apb(1'b1, OFS_ADDR, 32'h0);
		apb(1'b0, OFS_DATA, 32'h0);
		chk(q, 32'h9000);
		apb(1'b0, OFS_DATA, 32'h0);
		chk(q, 32'h9001);
		apb(1'b1, OFS_ADDR, 32'd2479);
		apb(1'b1, OFS_DATA, 32'h0555);
		apb(1'b0, OFS_ADDR, 32'h0);
		chk(q, 32'h0);
		apb(1'b1, OFS_ADDR, 32'd2479);
		apb(1'b0, OFS_DATA, 32'h0);
		chk(q, 32'h0555);
		apb(1'b0, 8'h10, 32'h0);
		chk({se, q[30:0]}, 32'h80000000);
	endtask : t_store
	// frame then one row shifted out; 15 of 16 bits reach the display
	task t_refresh;
		disp.strobe(3'b100);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(q[0], 1'b1);
		apb(1'b0, OFS_DATA, 32'h0);
		chk(q, 32'h9000);
		repeat (90) @(posedge clock);
		disp.strobe(3'b010);
		for (int i = 0; i < 80; i++) begin
			disp.strobe(3'b001);
			chk({17'h0, disp_data}, 32'h1000 + i);
		end
		disp.strobe(3'b001);
		chk(pattern_fault, 1'b1);
		repeat (90) @(posedge clock);
		apb(1'b1, OFS_CTRL, 32'h4);
		@(negedge clock);
		chk({host_status, host_flag}, 2'b11);
		apb(1'b1, OFS_STATUS, 32'h2);
		@(negedge clock);
		chk(pattern_fault, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h0);
	endtask : t_refresh
	task t_self;
		manual_self_check <= 1'b1;
		disp.strobe(3'b100);
		chk(self_check_request, 1'b1);
		repeat (90) @(posedge clock);
		disp.strobe(3'b010);
		for (int i = 0; i < 80; i++) begin
			disp.strobe(3'b001);
			chk({17'h0, disp_data}, i);
		end
		chk(pattern_fault, 1'b0);
		@(posedge clock);
		manual_self_check <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h1);
		@(negedge clock);
		chk(self_check_request, 1'b1);
		apb(1'b1, OFS_CTRL, 32'h0);
		@(negedge clock);
		chk(self_check_request, 1'b0);
	endtask : t_self
	task t_dma_gfx;
		apb(1'b1, OFS_CTRL, 32'h2);
		apb(1'b1, OFS_ADDR, 32'd7);
		dma_valid <= 1'b1;
		dma_data <= 16'h0abc;
		do @(posedge clock); while (dma_ready !== 1'b1);
		dma_valid <= 1'b0;
		apb(1'b1, OFS_ADDR, 32'd7);
		apb(1'b0, OFS_DATA, 32'h0);
		chk(q, 32'h0abc);
		gfx_in <= 16'h5a3c;
		gfx_ctrl_in <= 4'h9;
		repeat (2) @(posedge clock);
		chk({gfx_ctrl_out, gfx_out}, 20'h95a3c);
		// enable low must freeze the graphics register
		ce <= 1'b0;
		gfx_in <= 16'h0f0f;
		repeat (2) @(posedge clock);
		chk(gfx_out, 32'h5a3c);
		ce <= 1'b1;
		repeat (2) @(posedge clock);
		chk(gfx_out, 32'h0f0f);
	endtask : t_dma_gfx
	initial begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		t_store;
		t_refresh;
		t_self;
		t_dma_gfx;
		end_sim;
	end
	// generous bound: all scenarios need well under 3000 cycles
	initial begin
		#2000000;
		err_total++;
		end_sim;
	end
endmodule : testbench
